// ==== bench/dpm_pin_model.sv ====
`timescale 1ns/10ps
`default_nettype none
module dpm_pin_model
(
  // pin drive from the device
  input  wire logic [7:0] p0_pin_out,
  input  wire logic [7:0] p0_pin_oe,
  input  wire logic [3:0] p1_pin_out,
  input  wire logic [3:0] p1_pin_oe,
  // board levels on released pins
  input  wire logic [7:0] ext0,
  input  wire logic [3:0] ext1,
  // resolved pin levels
  output logic      [7:0] p0_pin_in,
  output logic      [3:0] p1_pin_in
);
  // extra selects on port 0
  // board parts drive only pins the device has let go, so no contention
  assign p0_pin_in = (p0_pin_oe & p0_pin_out) | (~p0_pin_oe & ext0);
  assign p1_pin_in = (p1_pin_oe & p1_pin_out) | (~p1_pin_oe & ext1);
endmodule : dpm_pin_model
`default_nettype wire

// ==== bench/tb_top.sv ====
`timescale 1ns/10ps
`default_nettype none
module tb_top
  import dpm_pkg::*;
;
  logic            sys_clk = 1'b0;
  logic            nrst    = 1'b0;
  dpm_sfr_req_s    sfr_req = '0;
  logic [1:0]      route   = 2'h1;
  dpm_port0_function_select_out_s alt_o   = '0;
  dpm_serial_out_s ser_o   = '0;
  logic [7:0]      ext0    = 8'hff;
  logic [3:0]      ext1    = 4'hf;
  logic [7:0]      rdata, p0_in, p0_out, p0_oe, p0_src, p0_snk, rv;
  logic [3:0]      p1_in, p1_out, p1_oe;
  logic            rvalid, on_p1, on_radio, miso, rxd, irq_a, irq_b, tmr_a, tmr_b, tmr_c;
  int              fails, checks;

  always #20 sys_clk = ~sys_clk;

  dpm_port_mux i_dpm_port_mux (.sys_clk(sys_clk), .nrst(nrst), .sfr_req(sfr_req), .sfr_rdata(rdata),
    .sfr_rvalid(rvalid), .serial_route_sel(route), .serial_on_port1(on_p1), .serial_on_radio(on_radio),
    .p0_pin_in(p0_in), .p0_pin_out(p0_out), .p0_pin_oe(p0_oe), .p0_source_high(p0_src),
    .p0_sink_high(p0_snk), .p1_pin_in(p1_in), .p1_pin_out(p1_out), .p1_pin_oe(p1_oe),
    .port0_function_select_out(alt_o), .serial_out(ser_o), .serial_miso(miso), .uart_rxd(rxd),
    .ext_interrupt_a_low(irq_a), .ext_interrupt_b_low(irq_b), .timer_a_input(tmr_a),
    .timer_b_input(tmr_b), .timer_c_input(tmr_c));

  dpm_pin_model i_dpm_pin_model (.p0_pin_out(p0_out), .p0_pin_oe(p0_oe), .p1_pin_out(p1_out),
    .p1_pin_oe(p1_oe), .ext0(ext0), .ext1(ext1), .p0_pin_in(p0_in), .p1_pin_in(p1_in));

  task automatic conclude();
    if (fails == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : conclude

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : cyc

  // one-cycle strobe; released at the next edge so calls never collide
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    sfr_req.wr    <= 1'b1;
    sfr_req.addr  <= a;
    sfr_req.wdata <= d;
    @(posedge sys_clk);
    sfr_req.wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a);
    @(posedge sys_clk);
    sfr_req.rd   <= 1'b1;
    sfr_req.addr <= a;
    @(posedge sys_clk);
    sfr_req.rd <= 1'b0;
    #1;
    rv = rvalid ? rdata : 8'hxx;
  endtask : rd

  task automatic t_reset();
    logic [7:0] adr [7] = '{ADDR_PORT0_DATA, ADDR_PORT1_DATA, ADDR_PORT0_DRIVE, ADDR_PORT0_DIRECTION,
                            ADDR_PORT0_FUNCTION, ADDR_PORT1_DIRECTION, ADDR_PORT1_FUNCTION};
    logic [7:0] exp [7] = '{8'hff, 8'h0f, 8'h00, 8'hff, 8'h00, 8'h04, 8'h00};
    cyc(3);
    check(p0_oe, 8'h00);
    check({4'h0, p1_oe}, 8'h0b);
    @(posedge sys_clk);
    nrst <= 1'b1;
    cyc(3);
    check(p0_oe, 8'h00);
    check({3'h0, tmr_a, tmr_b, rxd, irq_a, irq_b}, 8'h07);
    for (int i = 0; i < 7; i++)
    begin
      rd(adr[i]);
      check(rv, exp[i]);
    end
    rd(8'h81);
    check(rv, 8'h00);
  endtask : t_reset

  task automatic t_gpio();
    wr(ADDR_PORT0_DIRECTION, 8'h0f);
    wr(ADDR_PORT0_DATA, 8'h5a);
    @(posedge sys_clk);
    ext0 <= 8'h3c;
    cyc(2);
    check(p0_oe, 8'hf0);
    check(p0_in, 8'h5c);
    rd(ADDR_PORT0_DATA);
    check(rv, 8'h5c);
  endtask : t_gpio

  task automatic t_alt();
    wr(ADDR_PORT0_FUNCTION, 8'hff);
    wr(ADDR_PORT0_DIRECTION, 8'hff);
    @(posedge sys_clk);
    alt_o <= '{timer_out: 1'b1, uart_tx: 1'b0, pwm: 1'b1};
    cyc(2);
    check(p0_oe, 8'h85);
    check(p0_out & 8'h85, 8'h81);
    wr(ADDR_PORT0_DIRECTION, 8'h00);
    @(posedge sys_clk);
    alt_o <= '{timer_out: 1'b0, uart_tx: 1'b1, pwm: 1'b0};
    cyc(2);
    check(p0_oe, 8'h87);
    check(p0_out & 8'h85, 8'h04);
  endtask : t_alt

  task automatic t_irq();
    wr(ADDR_PORT0_FUNCTION, 8'h00);
    wr(ADDR_PORT0_DIRECTION, 8'hff);
    @(posedge sys_clk);
    ext0 <= 8'h00;
    cyc(3);
    check({5'h0, rxd, irq_a, irq_b}, 8'h07);
    wr(ADDR_PORT0_FUNCTION, 8'h1a);
    cyc(3);
    check({5'h0, rxd, irq_a, irq_b}, 8'h00);
    @(posedge sys_clk);
    ext0 <= 8'h08;
    cyc(3);
    check({5'h0, rxd, irq_a, irq_b}, 8'h02);
  endtask : t_irq

  task automatic t_timer();
    int n;
    wr(ADDR_PORT0_FUNCTION, 8'h20);
    @(posedge sys_clk);
    ext0 <= 8'h60;
    cyc(1);
    for (int i = 0; i < 8 && tmr_a !== 1'b1; i++)
      cyc(1);
    check({7'h0, tmr_a}, 8'h01);
    @(posedge sys_clk);
    ext0 <= 8'h40;
    #1;
    n = 1;
    // next sample of the new level lands exactly one period later
    while (tmr_a === 1'b1 && n < 10)
    begin
      cyc(1);
      n++;
    end
    check(8'(n), 8'(TIMER_SAMPLE_PERIOD));
    check({7'h0, tmr_b}, 8'h00);
  endtask : t_timer

  task automatic t_port1();
    logic [7:0] exp [4] = '{8'h00, 8'h02, 8'h01, 8'h01};
    for (int i = 0; i < 4; i++)
    begin
      @(posedge sys_clk);
      route <= 2'(i);
      cyc(1);
      check({6'h0, on_p1, on_radio}, exp[i]);
    end
    @(posedge sys_clk);
    route <= 2'h1;
    ser_o <= '{sck: 1'b1, mosi: 1'b0};
    ext1  <= 4'h0;
    wr(ADDR_PORT1_DIRECTION, 8'h0f);
    cyc(2);
    check({4'h0, p1_oe}, 8'h0b);
    check({6'h0, p1_out[1:0]}, 8'h01);
    check({7'h0, miso}, 8'h00);
    // port 0 pin as extra select
    wr(ADDR_PORT0_DIRECTION, 8'hfe);
    wr(ADDR_PORT0_DATA, 8'h00);
    cyc(2);
    check({6'h0, p0_in[0], p1_out[3]}, 8'h01);
    @(posedge sys_clk);
    route <= 2'h0;
    ext1  <= 4'h5;
    wr(ADDR_PORT1_DIRECTION, 8'h00);
    wr(ADDR_PORT1_FUNCTION, 8'hff);
    cyc(8);
    check({4'h0, p1_oe}, 8'h0a);
    check({6'h0, miso, tmr_c}, 8'h03);
    wr(ADDR_PORT1_DIRECTION, 8'h08);
    cyc(1);
    check({4'h0, p1_oe}, 8'h02);
    rd(ADDR_PORT1_FUNCTION);
    check(rv, 8'h0f);
    @(posedge sys_clk);
    route <= 2'h1;
    cyc(8);
    check({7'h0, tmr_c}, 8'h00);
  endtask : t_port1

  task automatic t_drive();
    logic [7:0] val [2] = '{8'hff, 8'h0f};
    for (int i = 0; i < 2; i++)
    begin
      wr(ADDR_PORT0_DRIVE, val[i]);
      cyc(1);
      check(p0_src, val[i] & 8'haa);
      check(p0_snk, val[i] & 8'h55);
    end
  endtask : t_drive

  task automatic t_rereset();
    @(posedge sys_clk);
    route <= 2'h0;
    nrst  <= 1'b0;
    cyc(2);
    check(p0_oe, 8'h00);
    check({4'h0, p1_oe}, 8'h0b);
    @(posedge sys_clk);
    nrst <= 1'b1;
    rd(ADDR_PORT0_FUNCTION);
    check(rv, 8'h00);
  endtask : t_rereset

  initial
  begin
    repeat (3000) @(posedge sys_clk);
    fails++;
    conclude();
  end

  initial
  begin
    t_reset();
    t_gpio();
    t_alt();
    t_irq();
    t_timer();
    t_port1();
    t_drive();
    t_rereset();
    conclude();
  end
endmodule : tb_top
`default_nettype wire

// ==== rtl/dpm_pkg.sv ====
package dpm_pkg;

  // special-function register addresses
  localparam logic [7:0] ADDR_PORT0_DATA      = 8'h80;
  localparam logic [7:0] ADDR_PORT1_DATA      = 8'h90;
  localparam logic [7:0] ADDR_PORT0_DRIVE     = 8'h93;
  localparam logic [7:0] ADDR_PORT0_DIRECTION = 8'h94;
  localparam logic [7:0] ADDR_PORT0_FUNCTION  = 8'h95;
  localparam logic [7:0] ADDR_PORT1_DIRECTION = 8'h96;
  localparam logic [7:0] ADDR_PORT1_FUNCTION  = 8'h97;

  // reset values
  localparam logic [7:0] RST_PORT0_DATA       = 8'hff;
  localparam logic [3:0] RST_PORT1_DATA       = 4'hf;
  localparam logic [7:0] RST_PORT0_DRIVE      = 8'h00;
  localparam logic [7:0] RST_PORT0_DIRECTION  = 8'hff;
  localparam logic [7:0] RST_PORT0_FUNCTION   = 8'h00;
  localparam logic [3:0] RST_PORT1_DIRECTION  = 4'h4;
  localparam logic [3:0] RST_PORT1_FUNCTION   = 4'h0;

  // port 0 alternate directions: forced outputs and forced inputs
  localparam logic [7:0] PORT0_FUNCTION_SELECT_OUT_MASK      = 8'h85;
  localparam logic [7:0] PORT0_FUNCTION_SELECT_IN_MASK       = 8'h78;
  localparam logic [7:0] P0_ODD_MASK          = 8'haa;
  localparam logic [7:0] P0_EVEN_MASK         = 8'h55;

  // port 0 field positions
  localparam int P0_BIT_TIMER_OUT = 0;
  localparam int P0_BIT_UART_RX   = 1;
  localparam int P0_BIT_UART_TX   = 2;
  localparam int P0_BIT_INT_A     = 3;
  localparam int P0_BIT_INT_B     = 4;
  localparam int P0_BIT_TIMER_A   = 5;
  localparam int P0_BIT_TIMER_B   = 6;
  localparam int P0_BIT_PWM       = 7;

  // port 1 field positions
  localparam int P1_BIT_SCK       = 0;
  localparam int P1_BIT_MOSI      = 1;
  localparam int P1_BIT_MISO      = 2;
  localparam int P1_BIT_CS        = 3;

  // port 1 directions in serial master mode (1 = driven)
  localparam logic [3:0] P1_SERIAL_OE = 4'hb;

  // routing select encodings
  localparam logic [1:0] ROUTE_CODE_UNUSED = 2'h0;
  localparam logic [1:0] ROUTE_CODE_PORT1  = 2'h1;

  // timer inputs are sampled once every this many clocks
  localparam int TIMER_SAMPLE_PERIOD = 4;
  localparam int TICK_CNT_W          = $clog2(TIMER_SAMPLE_PERIOD);
  localparam logic [TICK_CNT_W-1:0] TICK_CNT_LAST = TICK_CNT_W'(TIMER_SAMPLE_PERIOD - 1);

  typedef enum logic [1:0] {
    DPM_ROUTE_UNUSED,
    DPM_ROUTE_PORT1,
    DPM_ROUTE_RADIO
  } dpm_route_e;

  // register access request from the cpu
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } dpm_sfr_req_s;

  // alternate functions feeding port 0 outputs
  typedef struct packed {
    logic timer_out;
    logic uart_tx;
    logic pwm;
  } dpm_port0_function_select_out_s;

  // serial master engine signals toward port 1
  typedef struct packed {
    logic sck;
    logic mosi;
  } dpm_serial_out_s;

endpackage : dpm_pkg

// ==== rtl/dpm_port_mux.sv ====
// Overview of operation
// - port 0 pins all inputs during reset
// - port 1 takes serial master directions in reset
// - configuration holds reset state until software writes
// - function select outranks direction bit on port 0 pins other than pin 1
// - alternate pins 0,2,7 out; 3-6 in
// - uart receive pin follows direction bit 1
// - interrupts reach logic only when selected
// - timer inputs sampled every four clocks
// - unselected port 0 pin is general purpose
// - direction bit 0 output, 1 input
// - drive bit: odd pins source, even sink
// - port 1 registers hold four bits only
// - route 01 makes port 1 serial master
// - otherwise pin 0 may be timer c input
// - port 1 pin 2 always input
// - port 1 pin 3 output always from the latch
// - port 1 pins 1,3 ignore function select
// - routing select decodes unused, port 1, radio
`timescale 1ns/10ps
`default_nettype none
module dpm_port_mux
  import dpm_pkg::*;
(
  // clock and reset
  input  wire logic            sys_clk,
  input  wire logic            nrst,
  // cpu register access
  input  wire dpm_sfr_req_s    sfr_req,
  output logic      [7:0]      sfr_rdata,
  output logic                 sfr_rvalid,
  // serial routing select from the serial engine control
  input  wire logic [1:0]      serial_route_sel,
  output logic                 serial_on_port1,
  output logic                 serial_on_radio,
  // port 0 pins
  input  wire logic [7:0]      p0_pin_in,
  output logic      [7:0]      p0_pin_out,
  output logic      [7:0]      p0_pin_oe,
  output logic      [7:0]      p0_source_high,
  output logic      [7:0]      p0_sink_high,
  // port 1 pins
  input  wire logic [3:0]      p1_pin_in,
  output logic      [3:0]      p1_pin_out,
  output logic      [3:0]      p1_pin_oe,
  // peripheral outputs routed to port 0
  input  wire dpm_port0_function_select_out_s port0_function_select_out,
  // serial master engine
  input  wire dpm_serial_out_s serial_out,
  output logic                 serial_miso,
  // peripheral inputs taken from the pins
  output logic                 uart_rxd,
  output logic                 ext_interrupt_a_low,
  output logic                 ext_interrupt_b_low,
  output logic                 timer_a_input,
  output logic                 timer_b_input,
  output logic                 timer_c_input
);

  typedef struct packed {
    logic [7:0]            p0_data;
    logic [7:0]            p0_drive;
    logic [7:0]            port0_direction;
    logic [7:0]            p0_func;
    logic [3:0]            p1_data;
    logic [3:0]            port1_direction;
    logic [3:0]            p1_func;
    logic [TICK_CNT_W-1:0] tick_cnt;
    logic [7:0]            rdata;
    logic                  rvalid;
    logic [7:0]            p0_out;
    logic [3:0]            p1_out;
    logic                  miso;
    logic                  rxd;
    logic                  int_a_low;
    logic                  int_b_low;
  } dpm_state_s;

  dpm_state_s s_q;
  dpm_state_s s_d;

  dpm_route_e  route;
  logic        serial_mode;
  logic [7:0]  p0_forced;
  logic [7:0]  p0_oe;
  logic [3:0]  p1_oe;
  logic        tick;
  logic [2:0]  timer_raw;
  logic [2:0]  timer_smp;

  always_comb
  begin
    unique case (serial_route_sel)
      ROUTE_CODE_UNUSED: route = DPM_ROUTE_UNUSED;
      ROUTE_CODE_PORT1:  route = DPM_ROUTE_PORT1;
      default:           route = DPM_ROUTE_RADIO;
    endcase
  end

  // reset forces the serial master layout
  assign serial_mode     = !nrst || (route == DPM_ROUTE_PORT1);
  assign serial_on_port1 = route == DPM_ROUTE_PORT1;
  assign serial_on_radio = route == DPM_ROUTE_RADIO;

  assign p0_forced = s_q.p0_func & (PORT0_FUNCTION_SELECT_OUT_MASK | PORT0_FUNCTION_SELECT_IN_MASK);

  // oe is gated by reset directly so pins float even before a clock edge
  always_comb
  begin
    if (!nrst)
    begin
      p0_oe = 8'h00;
    end
    else
    begin
      p0_oe = (p0_forced & PORT0_FUNCTION_SELECT_OUT_MASK) | (~p0_forced & ~s_q.port0_direction);
    end
  end

  always_comb
  begin
    if (serial_mode)
    begin
      p1_oe = P1_SERIAL_OE;
    end
    else
    begin
      // pins 1 and 3 follow their direction bits
      p1_oe = ~s_q.port1_direction;
      // timer c input forces pin 0 to input
      if (s_q.p1_func[P1_BIT_SCK])
      begin
        p1_oe[P1_BIT_SCK] = 1'b0;
      end
    end
    p1_oe[P1_BIT_MISO] = 1'b0;
  end

  assign p0_pin_oe = p0_oe;
  assign p1_pin_oe = p1_oe;

  // high drive split by pin parity
  assign p0_source_high = s_q.p0_drive & P0_ODD_MASK;
  assign p0_sink_high   = s_q.p0_drive & P0_EVEN_MASK;

  assign tick = s_q.tick_cnt == TICK_CNT_LAST;

  // unselected pins leave timers idle low
  // timer c only when serial engine is elsewhere
  assign timer_raw[0] = s_q.p0_func[P0_BIT_TIMER_A] & p0_pin_in[P0_BIT_TIMER_A];
  assign timer_raw[1] = s_q.p0_func[P0_BIT_TIMER_B] & p0_pin_in[P0_BIT_TIMER_B];
  assign timer_raw[2] = !serial_mode & s_q.p1_func[P1_BIT_SCK] & p1_pin_in[P1_BIT_SCK];

  dpm_tick_sampler #(
    .WIDTH (3),
    .RST   (3'h0)
  ) u_timer_sampler (
    .sys_clk (sys_clk),
    .nrst    (nrst),
    .tick    (tick),
    .din     (timer_raw),
    .dout    (timer_smp)
  );

  assign timer_a_input = timer_smp[0];
  assign timer_b_input = timer_smp[1];
  assign timer_c_input = timer_smp[2];

  always_comb
  begin
    s_d        = s_q;
    s_d.rvalid = 1'b0;
    if (!nrst)
    begin
      s_d.p0_data   = RST_PORT0_DATA;
      s_d.p0_drive  = RST_PORT0_DRIVE;
      s_d.port0_direction    = RST_PORT0_DIRECTION;
      s_d.p0_func   = RST_PORT0_FUNCTION;
      s_d.p1_data   = RST_PORT1_DATA;
      s_d.port1_direction    = RST_PORT1_DIRECTION;
      s_d.p1_func   = RST_PORT1_FUNCTION;
      s_d.tick_cnt  = '0;
      s_d.rdata     = 8'h00;
      s_d.p0_out    = RST_PORT0_DATA;
      s_d.p1_out    = RST_PORT1_DATA;
      s_d.miso      = 1'b0;
      s_d.rxd       = 1'b1;
      s_d.int_a_low = 1'b1;
      s_d.int_b_low = 1'b1;
    end
    else
    begin
      s_d.tick_cnt = tick ? '0 : s_q.tick_cnt + 1'b1;

      // port 1 keeps only the low four bits
      if (sfr_req.wr)
      begin
        unique case (sfr_req.addr)
          ADDR_PORT0_DATA:      s_d.p0_data  = sfr_req.wdata;
          ADDR_PORT1_DATA:      s_d.p1_data  = sfr_req.wdata[3:0];
          ADDR_PORT0_DRIVE:     s_d.p0_drive = sfr_req.wdata;
          ADDR_PORT0_DIRECTION: s_d.port0_direction   = sfr_req.wdata;
          ADDR_PORT0_FUNCTION:  s_d.p0_func  = sfr_req.wdata;
          ADDR_PORT1_DIRECTION: s_d.port1_direction   = sfr_req.wdata[3:0];
          ADDR_PORT1_FUNCTION:  s_d.p1_func  = sfr_req.wdata[3:0];
          default:              s_d.rdata    = s_q.rdata;
        endcase
      end

      // reads see pin levels on inputs, latch on outputs
      if (sfr_req.rd)
      begin
        s_d.rvalid = 1'b1;
        unique case (sfr_req.addr)
          ADDR_PORT0_DATA:      s_d.rdata = (p0_oe & s_q.p0_data) | (~p0_oe & p0_pin_in);
          ADDR_PORT1_DATA:      s_d.rdata = {4'h0, (p1_oe & s_q.p1_data) | (~p1_oe & p1_pin_in)};
          ADDR_PORT0_DRIVE:     s_d.rdata = s_q.p0_drive;
          ADDR_PORT0_DIRECTION: s_d.rdata = s_q.port0_direction;
          ADDR_PORT0_FUNCTION:  s_d.rdata = s_q.p0_func;
          ADDR_PORT1_DIRECTION: s_d.rdata = {4'h0, s_q.port1_direction};
          ADDR_PORT1_FUNCTION:  s_d.rdata = {4'h0, s_q.p1_func};
          default:              s_d.rdata = 8'h00;
        endcase
      end

      // general purpose pins drive the latch
      s_d.p0_out = s_q.p0_data;
      if (s_q.p0_func[P0_BIT_TIMER_OUT])
      begin
        s_d.p0_out[P0_BIT_TIMER_OUT] = port0_function_select_out.timer_out;
      end
      if (s_q.p0_func[P0_BIT_UART_TX])
      begin
        s_d.p0_out[P0_BIT_UART_TX] = port0_function_select_out.uart_tx;
      end
      if (s_q.p0_func[P0_BIT_PWM])
      begin
        s_d.p0_out[P0_BIT_PWM] = port0_function_select_out.pwm;
      end

      // chip select pin always from the latch
      s_d.p1_out = s_q.p1_data;
      if (serial_mode)
      begin
        // engine drives clock and data out
        s_d.p1_out[P1_BIT_SCK]  = serial_out.sck;
        s_d.p1_out[P1_BIT_MOSI] = serial_out.mosi;
      end
      s_d.miso = p1_pin_in[P1_BIT_MISO];

      s_d.int_a_low = s_q.p0_func[P0_BIT_INT_A] ? p0_pin_in[P0_BIT_INT_A] : 1'b1;
      s_d.int_b_low = s_q.p0_func[P0_BIT_INT_B] ? p0_pin_in[P0_BIT_INT_B] : 1'b1;
      s_d.rxd       = s_q.p0_func[P0_BIT_UART_RX] ? p0_pin_in[P0_BIT_UART_RX] : 1'b1;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    s_q <= s_d;
  end

  assign sfr_rdata           = s_q.rdata;
  assign sfr_rvalid          = s_q.rvalid;
  assign p0_pin_out          = s_q.p0_out;
  assign p1_pin_out          = s_q.p1_out;
  assign serial_miso         = s_q.miso;
  assign uart_rxd            = s_q.rxd;
  assign ext_interrupt_a_low = s_q.int_a_low;
  assign ext_interrupt_b_low = s_q.int_b_low;

  // a direction or function register write on either port
  logic cfg_wr;
  assign cfg_wr = sfr_req.wr && (sfr_req.addr inside {ADDR_PORT0_DIRECTION, ADDR_PORT0_FUNCTION,
                                                     ADDR_PORT1_DIRECTION, ADDR_PORT1_FUNCTION});

  sequence seq_tick_gap;
    !tick [*3] ##1 tick;
  endsequence

  // latch write while every port 0 pin is general purpose
  sequence seq_p0_gpio_write;
    sfr_req.wr && sfr_req.addr == ADDR_PORT0_DATA && s_q.p0_func == 8'h00;
  endsequence

  AST_RST_P0_INPUT: assert property (@(posedge sys_clk) !nrst |-> p0_pin_oe == 8'h00)
    else $error("port 0 driven during reset");

  AST_RST_P1_SERIAL: assert property (@(posedge sys_clk) !nrst |-> p1_pin_oe == 4'hb)
    else $error("port 1 not serial layout during reset");

  AST_HOLD_AFTER_RST: assert property (@(posedge sys_clk) disable iff (!nrst)
    !$past(nrst) ##1 !$past(cfg_wr) |-> p0_pin_oe == 8'h00)
    else $error("port 0 direction left reset state without a write");

  AST_ALT_PRIORITY: assert property (@(posedge sys_clk) disable iff (!nrst)
    s_q.p0_func[7] && s_q.port0_direction[7] |-> p0_pin_oe[7])
    else $error("direction bit beat function select");

  AST_ALT_DIRS: assert property (@(posedge sys_clk) disable iff (!nrst)
    (p0_pin_oe & s_q.p0_func & 8'h78) == 8'h00 && (~p0_pin_oe & s_q.p0_func & 8'h85) == 8'h00)
    else $error("alternate direction wrong on port 0");

  AST_RXD_DIR: assert property (@(posedge sys_clk) disable iff (!nrst)
    s_q.p0_func[1] |-> p0_pin_oe[1] == !s_q.port0_direction[1])
    else $error("uart receive pin not following direction bit");

  AST_INT_GATE: assert property (@(posedge sys_clk) disable iff (!nrst)
    !s_q.p0_func[3] ##1 !$past(s_q.p0_func[3]) |-> ext_interrupt_a_low)
    else $error("interrupt passed while not selected");

  AST_TICK_PERIOD: assert property (@(posedge sys_clk) disable iff (!nrst)
    tick |=> seq_tick_gap)
    else $error("timer sample strobe not every four clocks");

  AST_GPIO_DIR: assert property (@(posedge sys_clk) disable iff (!nrst)
    s_q.p0_func == 8'h00 |-> p0_pin_oe == ~s_q.port0_direction)
    else $error("general purpose direction mismatch");

  AST_DRIVE_SPLIT: assert property (@(posedge sys_clk) disable iff (!nrst)
    (p0_source_high | p0_sink_high) == s_q.p0_drive && (p0_source_high & 8'h55) == 8'h00)
    else $error("drive strength split wrong");

  AST_SERIAL_OUT: assert property (@(posedge sys_clk) disable iff (!nrst)
    serial_on_port1 && $past(serial_on_port1) && $past(nrst)
      |-> p1_pin_oe == 4'hb && p1_pin_out[0] == $past(serial_out.sck))
    else $error("serial master clock not on port 1");

  AST_MISO_IN: assert property (@(posedge sys_clk) p1_pin_oe[2] == 1'b0)
    else $error("serial data input driven");

  AST_P1_GPIO: assert property (@(posedge sys_clk) disable iff (!nrst)
    !serial_mode |-> p1_pin_oe[3] == !s_q.port1_direction[3] && p1_pin_oe[1] == !s_q.port1_direction[1])
    else $error("port 1 pin ignored its direction bit");

  AST_LATCH_DRIVE: assert property (@(posedge sys_clk) disable iff (!nrst)
    seq_p0_gpio_write ##1 !sfr_req.wr |=> p0_pin_out == $past(sfr_req.wdata, 2))
    else $error("port 0 output not following latch");

endmodule : dpm_port_mux
`default_nettype wire

// ==== rtl/dpm_tick_sampler.sv ====
`timescale 1ns/10ps
`default_nettype none
module dpm_tick_sampler
  import dpm_pkg::*;
#(
  parameter int              WIDTH = 1,
  parameter logic [WIDTH-1:0] RST  = '0
)
(
  // clock and reset
  input  wire logic             sys_clk,
  input  wire logic             nrst,
  // sample strobe and data
  input  wire logic             tick,
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);

  logic [WIDTH-1:0] smp_q;
  logic [WIDTH-1:0] smp_d;

  always_comb
  begin
    smp_d = smp_q;
    if (!nrst)
    begin
      smp_d = RST;
    end
    else if (tick)
    begin
      smp_d = din;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    smp_q <= smp_d;
  end

  assign dout = smp_q;

endmodule : dpm_tick_sampler
`default_nettype wire
